// ==== design/uirq_defs.svh ====
/*
  Constants for the USB raw interrupt and enable block: register offsets, raw bit positions, bus responses.
  Assumes byte addresses on a 32-bit AXI4-Lite bus and one aligned word per register.
*/
// What this block does
// - raw bit 19 is high while any endpoint handshake flag is set and falls once all are cleared.
// - raw bit 18 is high while any endpoint abort-complete flag is set and falls once all are cleared.
// - in device mode raw bit 17 is set on each received frame start and cleared by a frame-number read.
// - raw bit 15 is set on host resume in device mode and cleared by a write of the engine resume flag.
// - in device mode raw bit 14 is set on any change of the sleep flag and cleared by a write of that flag.
// - in device mode raw bit 13 is set on any change of the device attach state and cleared by a write of the connected flag.
// - raw bit 4 is high while any buffer-done flag is set and falls once all are cleared.
// - raw bit 3 is set each time the transfer-finished flag becomes set.
// - software clears raw bit 3 by writing a one to that bit of the raw register.
// - in host mode raw bit 2 is set on each sent frame start and cleared by a frame-number read.
// - in host mode raw bit 1 is set on remote wake-up and cleared by a write of the engine resume flag.
// - in host mode raw bit 0 is set on a line speed change and cleared by a write of the speed field.
// - masked status is raw anded with enable, ored with force, bit for bit.
`ifndef UIRQ_DEFS_SVH
`define UIRQ_DEFS_SVH
`define UIRQ_OFS_RAW      8'h8C
`define UIRQ_OFS_ENA      8'h90
`define UIRQ_OFS_FORCE    8'h94
`define UIRQ_OFS_MASKED   8'h98
`define UIRQ_OFS_EVT_STAT 8'hA0
`define UIRQ_OFS_EVT_CLR  8'hA4
`define UIRQ_OFS_EVT_ENA  8'hA8
`define UIRQ_NBITS        20
`define UIRQ_B_EPHS       19
`define UIRQ_B_ABORT      18
`define UIRQ_B_DSOF       17
`define UIRQ_B_SETUP      16
`define UIRQ_B_DWAKE      15
`define UIRQ_B_DSLEEP     14
`define UIRQ_B_DATTACH    13
`define UIRQ_B_MIRROR_HI  12
`define UIRQ_B_MIRROR_LO  5
`define UIRQ_B_BUFDONE    4
`define UIRQ_B_TDONE      3
`define UIRQ_B_HSOF       2
`define UIRQ_B_HWAKE      1
`define UIRQ_B_HATTACH    0
`define UIRQ_EVT_RISE     0
`define UIRQ_EVT_BADADR   1
`define UIRQ_RESP_OKAY    2'h0
`define UIRQ_RESP_SLVERR  2'h2
`endif

// ==== design/uirq_pkg.sv ====
/*
  Types shared by the USB raw interrupt and enable block.
  Assumes uirq_defs.svh for widths.
*/
`include "uirq_defs.svh"
package uirq_pkg;
  typedef logic [`UIRQ_NBITS-1:0] uirq_vec_t;
  typedef logic [31:0]            uirq_word_t;
  typedef logic [1:0]             uirq_resp_t;
  typedef logic [1:0]             uirq_evt_t;
endpackage

// ==== design/uirq_core.sv ====
/*
  USB raw interrupt, enable, force and masked status registers behind an AXI4-Lite slave.
  Assumes all status inputs come from engine logic on aclk; pulses are one cycle wide.
*/
`timescale 1ns/1ps
`include "uirq_defs.svh"
module uirq_core (
  input  wire logic               aclk,                 // bus clock, 20 MHz
  input  wire logic               aresetn,              // synchronous reset, active low
  input  wire logic [7:0]         s_axi_awaddr,         // write address
  input  wire logic               s_axi_awvalid,        // write address valid
  output logic                    s_axi_awready,        // write address ready
  input  wire uirq_pkg::uirq_word_t s_axi_wdata,        // write data
  input  wire logic [3:0]         s_axi_wstrb,          // write byte enables
  input  wire logic               s_axi_wvalid,         // write data valid
  output logic                    s_axi_wready,         // write data ready
  output uirq_pkg::uirq_resp_t    s_axi_bresp,          // write response
  output logic                    s_axi_bvalid,         // write response valid
  input  wire logic               s_axi_bready,         // write response ready
  input  wire logic [7:0]         s_axi_araddr,         // read address
  input  wire logic               s_axi_arvalid,        // read address valid
  output logic                    s_axi_arready,        // read address ready
  output uirq_pkg::uirq_word_t    s_axi_rdata,          // read data
  output uirq_pkg::uirq_resp_t    s_axi_rresp,          // read response
  output logic                    s_axi_rvalid,         // read data valid
  input  wire logic               s_axi_rready,         // read data ready
  input  wire logic               host_mode,            // 1 host, 0 device
  input  wire logic [15:0]        endpoint_handshake_flags, // per-endpoint stall/nak flags
  input  wire logic [15:0]        abort_done_flags,     // per-endpoint abort complete
  input  wire logic [31:0]        buffer_done_flags,    // per-buffer completion
  input  wire logic               sof_rx_pulse,         // frame start received
  input  wire logic               sof_tx_pulse,         // frame start sent
  input  wire logic               frame_num_read,       // software read of frame number
  input  wire logic               setup_packet_flag,    // engine setup received
  input  wire logic               wake_seen_pulse,      // resume signalling detected
  input  wire logic               resume_flag_wr,       // software write of resume flag
  input  wire logic               sleep_flag,           // engine sleep_flag state
  input  wire logic               sleep_flag_wr,        // software write of sleep flag
  input  wire logic               attach_flag,          // device connected state
  input  wire logic               attach_flag_wr,       // software write of connected flag
  input  wire logic               bus_reset_flag,       // engine bus reset
  input  wire logic               supply_present_flag,  // engine supply detected
  input  wire logic               stall_handshake_flag, // engine stall received
  input  wire logic               crc_fail_flag,        // engine crc error
  input  wire logic               stuffing_fail_flag,   // engine stuffing_fail_flag
  input  wire logic               rx_overflow_flag,     // engine receive overflow
  input  wire logic               rx_timeout_flag,      // engine receive timeout
  input  wire logic               toggle_mismatch_flag, // engine data sequence error
  input  wire logic               transfer_finished,    // engine transfer-finished flag
  input  wire logic [1:0]         line_speed,           // detected line speed
  input  wire logic               line_speed_wr,        // software write of speed field
  output logic                    usb_irq,              // request to processor, level
  output logic                    evt_irq               // block event interrupt, level
);
  import uirq_pkg::*;

  uirq_vec_t  raw_w;
  uirq_vec_t  masked_w;
  uirq_vec_t  ena_r;
  uirq_vec_t  force_r;
  logic       dsof_r, dwake_r, dsleep_r, dattach_r, tdone_r, hsof_r, hwake_r, hattach_r;
  logic       prime_r;
  logic       sleep_prev_r, attach_prev_r, tdone_prev_r;
  logic [1:0] speed_prev_r;
  logic       aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  uirq_word_t wdata_r;
  logic [3:0] wstrb_r;
  logic       wr_fire;
  logic       wr_hit;
  logic       rd_fire;
  uirq_word_t rd_word;
  logic       rd_hit;
  logic       irq_prev_r;
  uirq_evt_t  evt_stat_r;
  uirq_evt_t  evt_ena_r;
  uirq_evt_t  evt_set;
  logic       tdone_w1c;
  logic       sleep_chg, attach_chg, speed_chg, tdone_rise;

  // level summaries, direct mirrors and sticky bits
  always_comb begin
    raw_w                    = '0;
    raw_w[`UIRQ_B_EPHS]      = |endpoint_handshake_flags;
    raw_w[`UIRQ_B_ABORT]     = |abort_done_flags;
    raw_w[`UIRQ_B_DSOF]      = dsof_r;
    raw_w[`UIRQ_B_SETUP]     = setup_packet_flag;
    raw_w[`UIRQ_B_DWAKE]     = dwake_r;
    raw_w[`UIRQ_B_DSLEEP]    = dsleep_r;
    raw_w[`UIRQ_B_DATTACH]   = dattach_r;
    raw_w[`UIRQ_B_MIRROR_HI:`UIRQ_B_MIRROR_LO] = {bus_reset_flag, supply_present_flag, stall_handshake_flag,
                                crc_fail_flag,
                                stuffing_fail_flag, rx_overflow_flag, rx_timeout_flag,
                                toggle_mismatch_flag};
    raw_w[`UIRQ_B_BUFDONE]   = |buffer_done_flags;
    raw_w[`UIRQ_B_TDONE]     = tdone_r;
    raw_w[`UIRQ_B_HSOF]      = hsof_r;
    raw_w[`UIRQ_B_HWAKE]     = hwake_r;
    raw_w[`UIRQ_B_HATTACH]   = hattach_r;
  end

  assign masked_w = (raw_w & ena_r) | force_r;
  assign usb_irq  = |masked_w;

  // previous values of level flags; first cycle after reset only loads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prime_r       <= 1'b0;
      sleep_prev_r  <= 1'b0;
      attach_prev_r <= 1'b0;
      tdone_prev_r  <= 1'b0;
      speed_prev_r  <= 2'h0;
    end else begin
      prime_r       <= 1'b1;
      sleep_prev_r  <= sleep_flag;
      attach_prev_r <= attach_flag;
      tdone_prev_r  <= transfer_finished;
      speed_prev_r  <= line_speed;
    end
  end

  assign sleep_chg  = prime_r && (sleep_flag != sleep_prev_r);
  assign attach_chg = prime_r && (attach_flag != attach_prev_r);
  assign speed_chg  = prime_r && (line_speed != speed_prev_r);
  assign tdone_rise = prime_r && transfer_finished && !tdone_prev_r;
  assign tdone_w1c  = wr_fire && (awaddr_r == `UIRQ_OFS_RAW) && wstrb_r[0] && wdata_r[`UIRQ_B_TDONE];

  // sticky bits: a set in the same cycle as its clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsof_r    <= 1'b0;
      dwake_r   <= 1'b0;
      dsleep_r  <= 1'b0;
      dattach_r <= 1'b0;
      tdone_r   <= 1'b0;
      hsof_r    <= 1'b0;
      hwake_r   <= 1'b0;
      hattach_r <= 1'b0;
    end else begin
      dsof_r    <= (!host_mode && sof_rx_pulse) || (dsof_r && !frame_num_read);
      dwake_r   <= (!host_mode && wake_seen_pulse) || (dwake_r && !resume_flag_wr);
      dsleep_r  <= (!host_mode && sleep_chg) || (dsleep_r && !sleep_flag_wr);
      dattach_r <= (!host_mode && attach_chg) || (dattach_r && !attach_flag_wr);
      tdone_r   <= tdone_rise || (tdone_r && !tdone_w1c);
      hsof_r    <= (host_mode && sof_tx_pulse) || (hsof_r && !frame_num_read);
      hwake_r   <= (host_mode && wake_seen_pulse) || (hwake_r && !resume_flag_wr);
      hattach_r <= (host_mode && speed_chg) || (hattach_r && !line_speed_wr);
    end
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

  always_comb begin
    unique case (awaddr_r)
      `UIRQ_OFS_RAW, `UIRQ_OFS_ENA, `UIRQ_OFS_FORCE, `UIRQ_OFS_MASKED,
      `UIRQ_OFS_EVT_STAT, `UIRQ_OFS_EVT_CLR, `UIRQ_OFS_EVT_ENA: wr_hit = 1'b1;
      default:                                                  wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UIRQ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `UIRQ_RESP_OKAY : `UIRQ_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // enable and force registers with byte lanes; bits above 19 stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena_r   <= '0;
      force_r <= '0;
    end else if (wr_fire) begin
      for (int b = 0; b < `UIRQ_NBITS; b++) begin
        if (wstrb_r[b/8] && awaddr_r == `UIRQ_OFS_ENA) begin
          ena_r[b] <= wdata_r[b];
        end
        if (wstrb_r[b/8] && awaddr_r == `UIRQ_OFS_FORCE) begin
          force_r[b] <= wdata_r[b];
        end
      end
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `UIRQ_OFS_RAW:      rd_word[`UIRQ_NBITS-1:0] = raw_w;
      `UIRQ_OFS_ENA:      rd_word[`UIRQ_NBITS-1:0] = ena_r;
      `UIRQ_OFS_FORCE:    rd_word[`UIRQ_NBITS-1:0] = force_r;
      `UIRQ_OFS_MASKED:   rd_word[`UIRQ_NBITS-1:0] = masked_w;
      `UIRQ_OFS_EVT_STAT: rd_word[1:0]             = evt_stat_r;
      `UIRQ_OFS_EVT_CLR:  rd_word                  = 32'h00000000;
      `UIRQ_OFS_EVT_ENA:  rd_word[1:0]             = evt_ena_r;
      default:            rd_hit                   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `UIRQ_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `UIRQ_RESP_OKAY : `UIRQ_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // block events: request rising edge and unmapped accesses
  always_comb begin
    evt_set                   = 2'h0;
    evt_set[`UIRQ_EVT_RISE]   = usb_irq && !irq_prev_r;
    evt_set[`UIRQ_EVT_BADADR] = (wr_fire && !wr_hit) || (rd_fire && !rd_hit);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev_r <= 1'b0;
      evt_stat_r <= 2'h0;
      evt_ena_r  <= 2'h0;
    end else begin
      irq_prev_r <= usb_irq;
      if (wr_fire && awaddr_r == `UIRQ_OFS_EVT_CLR && wstrb_r[0]) begin
        evt_stat_r <= evt_set | (evt_stat_r & ~wdata_r[1:0]);
      end else begin
        evt_stat_r <= evt_set | evt_stat_r;
      end
      if (wr_fire && awaddr_r == `UIRQ_OFS_EVT_ENA && wstrb_r[0]) begin
        evt_ena_r <= wdata_r[1:0];
      end
    end
  end

  assign evt_irq = |(evt_stat_r & evt_ena_r);

  // summary bits are checked through the read path that software uses
  stall_nak_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == `UIRQ_OFS_RAW |=>
    s_axi_rdata[`UIRQ_B_EPHS] == ($past(endpoint_handshake_flags) != 16'h0000))
    else $error("raw bit 19 wrong");
  abort_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == `UIRQ_OFS_RAW |=>
    s_axi_rdata[`UIRQ_B_ABORT] == ($past(abort_done_flags) != 16'h0000))
    else $error("raw bit 18 wrong");
  device_frame_start_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!host_mode && sof_rx_pulse) || (raw_w[`UIRQ_B_DSOF] && !frame_num_read) |=>
    raw_w[`UIRQ_B_DSOF])
    else $error("frame start lost");
  sleep_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
    prime_r && !host_mode && $changed(sleep_flag) |-> ##1 raw_w[`UIRQ_B_DSLEEP])
    else $error("sleep change lost");
  buffer_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == `UIRQ_OFS_RAW |=>
    s_axi_rdata[`UIRQ_B_BUFDONE] == ($past(buffer_done_flags) != 32'h00000000))
    else $error("raw bit 4 wrong");
  tdone_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    prime_r && $rose(transfer_finished) |=> raw_w[`UIRQ_B_TDONE])
    else $error("bit 3 not raised");
  tdone_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tdone_w1c && !tdone_rise |=> !raw_w[`UIRQ_B_TDONE])
    else $error("bit 3 not cleared");
  host_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_mode && wake_seen_pulse |=> raw_w[`UIRQ_B_HWAKE])
    else $error("host wake lost");
  host_speed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_mode && prime_r && $changed(line_speed) |=> raw_w[`UIRQ_B_HATTACH])
    else $error("speed change lost");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == `UIRQ_OFS_MASKED |=>
    s_axi_rdata == {12'h000, ($past(raw_w) & $past(ena_r)) | $past(force_r)} &&
    (s_axi_rdata != 32'h00000000) == $past(usb_irq))
    else $error("request level wrong");
  enable_reset_a: assert property (@(posedge aclk)
    !aresetn |=> ena_r == 20'h00000)
    else $error("enable not reset");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid ##1 $stable(ena_r))
    else $error("no write response");

endmodule // uirq_core

// ==== verif/uirq_engine_model.sv ====
/*
  Model of the engine status logic and software strobes that feed the raw interrupt block.
  Assumes the bench calls its tasks right after rising aclk edges; every output changes only here.
*/
`timescale 1ns/1ps
module uirq_engine_model (
  input  wire logic        aclk, // bus clock
  output logic             hm,   // host mode level
  output logic [8:0]       mir,  // mirrored engine flags, setup first
  output logic [15:0]      eph,  // endpoint handshake flags
  output logic [15:0]      abt,  // abort done flags
  output logic [31:0]      bufd, // buffer done flags
  output logic             slp,  // sleep state
  output logic             att,  // attach state
  output logic             tfin, // transfer finished level
  output logic [1:0]       spd,  // line speed
  output logic [7:0]       p     // one-cycle strobes
);
  task automatic flags(input logic [8:0] m, input logic [15:0] e, input logic [15:0] b, input logic [31:0] d);
    mir  <= m;
    eph  <= e;
    abt  <= b;
    bufd <= d;
  endtask
  task automatic levels(input logic h, input logic s, input logic a, input logic f, input logic [1:0] sp);
    hm   <= h;
    slp  <= s;
    att  <= a;
    tfin <= f;
    spd  <= sp;
  endtask
  // all quiet, device mode
  task automatic idle();
    flags(9'h000, 16'h0000, 16'h0000, 32'h00000000);
    levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    p <= 8'h00;
  endtask
  // strobes last exactly one cycle, as the engine and software give them
  task automatic pulse(input int i);
    @(posedge aclk);
    p[i] <= 1'b1;
    @(posedge aclk);
    p[i] <= 1'b0;
  endtask
endmodule // uirq_engine_model

// ==== verif/usb_irq_raw_and_enable_tb_top.sv ====
/*
  Self-checking bench for uirq_core: AXI4-Lite master, engine model, queued expectations.
  Assumes the offsets and bit positions of uirq_defs.svh.
*/
`timescale 1ns/1ps
`include "uirq_defs.svh"
module usb_irq_raw_and_enable_tb_top;
  import uirq_pkg::*;
  typedef struct {logic w; uirq_resp_t r; uirq_word_t d;} uirq_exp_t;
  logic       aclk, aresetn, awv, wv, bred, arv, rred, awr, wrd, bv, arr, rv, irq, eirq, hm, slp, att, tfin;
  logic [7:0] awa, ara, p;
  logic [3:0] strb;
  uirq_word_t wd, rdat, e, v, w, seed, cyc;
  uirq_resp_t br, rr;
  logic [8:0] mir;
  logic [15:0] eph, abt;
  logic [31:0] bufd;
  logic [1:0] spd;
  int         err_total, check_count, i;
  int         cp[7] = '{2, 4, 5, 6, 2, 4, 7};
  int         cb[7] = '{17, 15, 14, 13, 2, 1, 0};
  uirq_exp_t  q[$];
  uirq_exp_t  x;

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  uirq_engine_model eng (.aclk(aclk), .hm(hm), .mir(mir), .eph(eph), .abt(abt), .bufd(bufd), .slp(slp),
    .att(att), .tfin(tfin), .spd(spd), .p(p));

  uirq_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bred), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rred), .host_mode(hm),
    .endpoint_handshake_flags(eph), .abort_done_flags(abt), .buffer_done_flags(bufd), .sof_rx_pulse(p[0]),
    .sof_tx_pulse(p[1]), .frame_num_read(p[2]), .setup_packet_flag(mir[8]), .wake_seen_pulse(p[3]),
    .resume_flag_wr(p[4]), .sleep_flag(slp), .sleep_flag_wr(p[5]), .attach_flag(att), .attach_flag_wr(p[6]),
    .bus_reset_flag(mir[7]), .supply_present_flag(mir[6]), .stall_handshake_flag(mir[5]),
    .crc_fail_flag(mir[4]), .stuffing_fail_flag(mir[3]), .rx_overflow_flag(mir[2]), .rx_timeout_flag(mir[1]),
    .toggle_mismatch_flag(mir[0]), .transfer_finished(tfin), .line_speed(spd), .line_speed_wr(p[7]),
    .usb_irq(irq), .evt_irq(eirq));

  function automatic uirq_word_t xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input uirq_word_t ex, input uirq_word_t s);
    check_count++;
    if (s !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input uirq_word_t d, input uirq_resp_t r);
    bit ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    q.push_back('{1'b1, r, 32'h0});
    @(posedge aclk);
    {awa, wd, awv, wv, bred} <= {a, d, 3'h7};
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wrd) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bv);
    bred <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input uirq_word_t d, input uirq_resp_t r);
    q.push_back('{1'b0, r, d});
    @(posedge aclk);
    {ara, arv, rred} <= {a, 2'h3};
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    rred <= 1'b0;
  endtask

  task automatic ck(input logic a, input logic b);
    @(negedge aclk);
    chk("usb_irq", {31'h0, a}, {31'h0, irq});
    chk("evt_irq", {31'h0, b}, {31'h0, eirq});
  endtask

  // takes the oldest note whenever a response is handed over
  always @(posedge aclk) begin
    if ((rv && rred) || (bv && bred)) begin
      x = q.pop_front();
      chk("response", {30'h0, x.r}, {30'h0, (rv ? rr : br)});
      if (!x.w) chk("read data", x.d, rdat);
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h1388) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    {awv, wv, bred, arv, rred, awa, ara, wd, aresetn} = '0;
    eng.idle();
    {strb, seed, cyc, err_total, check_count} = {4'hF, 32'hC84DFD3E, 32'h0, 64'h0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`UIRQ_OFS_ENA, 32'h0, `UIRQ_RESP_OKAY);
    rd(`UIRQ_OFS_RAW, 32'h0, `UIRQ_RESP_OKAY);
    e = 32'h0;
    for (i = 0; i < 4; i++) begin
      v = xs();
      w = xs();
      // random byte lanes: only enabled lanes land
      strb <= w[3:0];
      w = {{8{w[3]}}, {8{w[2]}}, {8{w[1]}}, {8{w[0]}}};
      e = (e & ~w) | (v & w);
      wr(`UIRQ_OFS_ENA, v, `UIRQ_RESP_OKAY);
      rd(`UIRQ_OFS_ENA, e & 32'h000FFFFF, `UIRQ_RESP_OKAY);
    end
    strb <= 4'hF;
    wr(`UIRQ_OFS_ENA, 32'h0, `UIRQ_RESP_OKAY);
    for (i = 0; i < 6; i++) begin
      v = xs();
      w = xs();
      e = xs();
      @(posedge aclk);
      eng.flags(v[8:0], w[15:0] & {16{v[9]}}, w[31:16] & {16{v[10]}}, e & {32{v[11]}});
      e = {12'h0, v[9] && w[15:0] != 0, v[10] && w[31:16] != 0, 1'b0, v[8], 3'h0, v[7:0], v[11] && e != 0, 4'h0};
      rd(`UIRQ_OFS_RAW, e, `UIRQ_RESP_OKAY);
    end
    @(posedge aclk);
    eng.flags(9'h000, 16'h0000, 16'h0000, 32'h00000000);
    rd(`UIRQ_OFS_RAW, 32'h0, `UIRQ_RESP_OKAY);
    eng.pulse(0);
    eng.pulse(1);
    eng.pulse(3);
    @(posedge aclk);
    eng.levels(hm, ~slp, ~att, 1'b1, spd + 2'h1);
    e = 32'h0002E008;
    rd(`UIRQ_OFS_RAW, e, `UIRQ_RESP_OKAY);
    strb <= 4'hE;
    wr(`UIRQ_OFS_RAW, 32'h8, `UIRQ_RESP_OKAY);
    rd(`UIRQ_OFS_RAW, e, `UIRQ_RESP_OKAY);
    strb <= 4'hF;
    wr(`UIRQ_OFS_RAW, 32'h8, `UIRQ_RESP_OKAY);
    e[3] = 1'b0;
    rd(`UIRQ_OFS_RAW, e, `UIRQ_RESP_OKAY);
    for (i = 0; i < 7; i++) begin
      if (i == 4) begin
        @(posedge aclk);
        eng.levels(1'b1, ~slp, att, tfin, spd);
        eng.pulse(1);
        eng.pulse(3);
        eng.pulse(0);
        @(posedge aclk);
        eng.levels(hm, slp, att, tfin, spd + 2'h1);
        e = 32'h7;
        rd(`UIRQ_OFS_RAW, e, `UIRQ_RESP_OKAY);
      end
      eng.pulse(cp[i]);
      e[cb[i]] = 1'b0;
      rd(`UIRQ_OFS_RAW, e, `UIRQ_RESP_OKAY);
    end
    @(posedge aclk);
    eng.flags(9'h1FF, eph, abt, bufd);
    wr(`UIRQ_OFS_ENA, 32'h100, `UIRQ_RESP_OKAY);
    ck(1'b1, 1'b0);
    rd(`UIRQ_OFS_MASKED, 32'h100, `UIRQ_RESP_OKAY);
    wr(`UIRQ_OFS_ENA, 32'h0, `UIRQ_RESP_OKAY);
    ck(1'b0, 1'b0);
    wr(`UIRQ_OFS_FORCE, 32'h80000, `UIRQ_RESP_OKAY);
    rd(`UIRQ_OFS_MASKED, 32'h80000, `UIRQ_RESP_OKAY);
    ck(1'b1, 1'b0);
    wr(`UIRQ_OFS_FORCE, 32'h0, `UIRQ_RESP_OKAY);
    wr(`UIRQ_OFS_EVT_ENA, 32'h3, `UIRQ_RESP_OKAY);
    rd(8'h50, 32'h0, `UIRQ_RESP_SLVERR);
    wr(8'h54, 32'hFFFF, `UIRQ_RESP_SLVERR);
    rd(`UIRQ_OFS_EVT_STAT, 32'h3, `UIRQ_RESP_OKAY);
    ck(1'b0, 1'b1);
    wr(`UIRQ_OFS_EVT_CLR, 32'h3, `UIRQ_RESP_OKAY);
    rd(`UIRQ_OFS_EVT_STAT, 32'h0, `UIRQ_RESP_OKAY);
    ck(1'b0, 1'b0);
    test_done();
  end
endmodule // usb_irq_raw_and_enable_tb_top
